// [cpf_consts.svh]
`ifndef CPF_CONSTS_SVH
`define CPF_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CPF_OFS_ENV_CFG 12'h000
`define CPF_OFS_GP_OUT 12'h004
`define CPF_OFS_PIN_STAT 12'h008

// ----------------------------------------------------------------------
// Field positions in environment_terminal_config
// ----------------------------------------------------------------------
`define CPF_CMP2_FUNC_LSB 8
`define CPF_CMP3_FUNC_LSB 10
`define CPF_CMP4_FUNC_LSB 12
`define CPF_CMP5_FUNC_LSB 14
`define CPF_FUNC_W 2

// ----------------------------------------------------------------------
// Field positions in the pin status register
// ----------------------------------------------------------------------
`define CPF_STAT_LEVEL_LSB 0
`define CPF_STAT_OE_LSB 4
`define CPF_STAT_OUT_LSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CPF_RST_ENV_CFG 32'h0000_0000
`define CPF_RST_GP_OUT 4'h0

`endif

// [cpf_pkg.sv]
package cpf_pkg;

    // Terminal function codes
    typedef enum logic [1:0] {
        CPF_GP_IN = 2'h0,
        CPF_GP_OUT = 2'h1,
        CPF_MATCH_LOW = 2'h2,
        CPF_MATCH_HIGH = 2'h3
    } cpf_pin_func_t;

    // Whole state of the top module
    typedef struct packed {
        logic [31:0] env_cfg;
        logic [3:0] gp_out;
        logic [3:0] gp_in;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } cpf_state_t;

endpackage

// [cpf_pin_func.sv]
`timescale 1ns/1ps
`default_nettype none

module cpf_pin_func
    import cpf_pkg::*;
(
    // Selection
    input wire cpf_pin_func_t func,
    // Sources
    input wire logic match,
    input wire logic gp_level,
    // Pin drive
    output logic pin_out,
    output logic pin_oe
);

    // ------------------------------------------------------------------
    // Function decode
    // ------------------------------------------------------------------
    always_comb begin
        unique case (func)
            CPF_GP_IN: begin
                pin_out = 1'h0;
                pin_oe = 1'h0;
            end
            CPF_GP_OUT: begin
                pin_out = gp_level;
                pin_oe = 1'h1;
            end
            CPF_MATCH_LOW: begin
                pin_out = ~match;
                pin_oe = 1'h1;
            end
            CPF_MATCH_HIGH: begin
                pin_out = match;
                pin_oe = 1'h1;
            end
        endcase
    end

endmodule

`default_nettype wire

// [cpf_comparator_pin_function_select.sv]
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "cpf_consts.svh"

module cpf_comparator_pin_function_select
    import cpf_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator match signals
    input wire logic cmp2_match_out,
    input wire logic cmp3_match_out,
    input wire logic cmp4_match_out,
    input wire logic cmp5_match_out,
    // Shared terminals, index 0 is comparator 2 up to 3 for comparator 5
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    // General-purpose port logic
    output logic [3:0] gp_in_level
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic cpf_pin_func_t field_of(
        input logic [31:0] cfg,
        input int lsb
    );
        return cpf_pin_func_t'(cfg[lsb +: `CPF_FUNC_W]);
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_W'(`CPF_OFS_ENV_CFG)) ||
            (a == ADDR_W'(`CPF_OFS_GP_OUT)) ||
            (a == ADDR_W'(`CPF_OFS_PIN_STAT));
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cpf_state_t state_reg;
    cpf_state_t state_next;

    cpf_pin_func_t func_sel [4];
    logic [3:0] match_vec;
    logic [3:0] cell_out;
    logic [3:0] cell_oe;
    logic access_done;
    logic access_pend;
    logic [31:0] read_mux;
    logic [31:0] gp_merge;

    assign match_vec = {cmp5_match_out, cmp4_match_out, cmp3_match_out, cmp2_match_out};

    // ------------------------------------------------------------------
    // Field selection per terminal
    // ------------------------------------------------------------------
    always_comb begin
        func_sel[0] = field_of(state_reg.env_cfg, `CPF_CMP2_FUNC_LSB);
        func_sel[1] = field_of(state_reg.env_cfg, `CPF_CMP3_FUNC_LSB);
        func_sel[2] = field_of(state_reg.env_cfg, `CPF_CMP4_FUNC_LSB);
        func_sel[3] = field_of(state_reg.env_cfg, `CPF_CMP5_FUNC_LSB);
    end

    // ------------------------------------------------------------------
    // Terminal function cells
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_cell
        cpf_pin_func u_cell (
            .func(func_sel[i]),
            .match(match_vec[i]),
            .gp_level(state_reg.gp_out[i]),
            .pin_out(cell_out[i]),
            .pin_oe(cell_oe[i])
        );
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        read_mux = 32'h0000_0000;
        if (paddr == ADDR_W'(`CPF_OFS_GP_OUT)) begin
            read_mux[3:0] = state_reg.gp_out;
        end else if (paddr == ADDR_W'(`CPF_OFS_PIN_STAT)) begin
            read_mux[`CPF_STAT_LEVEL_LSB +: 4] = state_reg.gp_in;
            read_mux[`CPF_STAT_OE_LSB +: 4] = state_reg.pin_oe;
            read_mux[`CPF_STAT_OUT_LSB +: 4] = state_reg.pin_out;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        gp_merge = 32'h0000_0000;
        access_pend = psel && penable && !state_reg.pready;
        access_done = psel && penable && state_reg.pready;

        state_next.pready = access_pend;
        state_next.pslverr = access_pend && !is_mapped(paddr);
        state_next.prdata = (access_pend && !pwrite) ? read_mux : 32'h0000_0000;

        if (access_done && pwrite) begin
            if (paddr == ADDR_W'(`CPF_OFS_ENV_CFG)) begin
                state_next.env_cfg = merge_strb(state_reg.env_cfg, pwdata, pstrb);
            end else if (paddr == ADDR_W'(`CPF_OFS_GP_OUT)) begin
                gp_merge = merge_strb({28'h0000000, state_reg.gp_out}, pwdata, pstrb);
                state_next.gp_out = gp_merge[3:0];
            end
        end

        state_next.gp_in = pin_in;
        state_next.pin_out = cell_out;
        state_next.pin_oe = cell_oe;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.env_cfg <= `CPF_RST_ENV_CFG;
            state_reg.gp_out <= `CPF_RST_GP_OUT;
            state_reg.gp_in <= 4'h0;
            state_reg.pin_out <= 4'h0;
            state_reg.pin_oe <= 4'h0;
            state_reg.pready <= 1'h0;
            state_reg.pslverr <= 1'h0;
            state_reg.prdata <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign pin_out = state_reg.pin_out;
    assign pin_oe = state_reg.pin_oe;
    assign gp_in_level = state_reg.gp_in;

endmodule

`default_nettype wire

// [cpf_select_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Terminal select checks
// --------------------------------
module cpf_select_checker #(
    parameter int ADDR_W = 12
) (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    // Terminals
    input wire logic [3:0] m,
    input wire logic [3:0] pin_in,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] gp_in_level
);
    logic [15:0] cfg;
    logic [3:0] gp;
    logic [3:0] e_oe;
    logic [3:0] e_out;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 16'h0000;
            gp <= 4'h0;
        end else if (psel && penable && pready && pwrite) begin
            for (int b = 0; b < 2; b++) begin
                if (pstrb[b] && paddr == 12'h000) begin
                    cfg[8*b+:8] <= pwdata[8*b+:8];
                end
            end
            if (pstrb[0] && paddr == 12'h004) begin
                gp <= pwdata[3:0];
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            e_oe[i] = cfg[8+2*i+:2] != 2'h0;
            case (cfg[8+2*i+:2])
                2'h1: e_out[i] = gp[i];
                2'h2: e_out[i] = !m[i];
                2'h3: e_out[i] = m[i];
                default: e_out[i] = 1'b0;
            endcase
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_cmp2_pin: assert property ({pin_oe[0], pin_out[0]} == $past({e_oe[0], e_out[0]}))
        else $error("cmp2 terminal drive wrong");
    a_cmp3_pin: assert property ({pin_oe[1], pin_out[1]} == $past({e_oe[1], e_out[1]}))
        else $error("cmp3 terminal drive wrong");
    a_cmp4_pin: assert property ({pin_oe[2], pin_out[2]} == $past({e_oe[2], e_out[2]}))
        else $error("cmp4 terminal drive wrong");
    a_cmp5_pin: assert property ({pin_oe[3], pin_out[3]} == $past({e_oe[3], e_out[3]}))
        else $error("cmp5 terminal drive wrong");
    a_level_sample: assert property ($past(presetn) |-> gp_in_level == $past(pin_in))
        else $error("sampled level wrong");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_time: assert property (psel && $rose(penable) |=> pready)
        else $error("ready late");
    a_err_map: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
        else $error("error response wrong");
endmodule
bind cpf_comparator_pin_function_select cpf_select_checker #(.ADDR_W(ADDR_W)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .m({cmp5_match_out, cmp4_match_out, cmp3_match_out, cmp2_match_out}),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .gp_in_level(gp_in_level));
`default_nettype wire

// [cpf_term_model.sv]
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Outside circuits on the terminals
// --------------------------------
module cpf_term_model (
    // Device drive and outside level
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] ext_level,
    // Wire level
    output logic [3:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// [test_comparator_pin_function_select.sv]
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Register and terminal tests
// --------------------------------
module test_comparator_pin_function_select;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cv;
    logic [3:0] m, ext, pin_in, pin_out, pin_oe, lvl, strb;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    cpf_comparator_pin_function_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp2_match_out(m[0]),
        .cmp3_match_out(m[1]), .cmp4_match_out(m[2]), .cmp5_match_out(m[3]),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .gp_in_level(lvl));
    cpf_term_model tm_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] stat(input logic [31:0] c, input logic [3:0] mm);
        logic [3:0] oe;
        logic [3:0] o;
        for (int i = 0; i < 4; i++) begin
            oe[i] = c[8+2*i+:2] != 2'h0;
            o[i] = c[8+2*i+:2] == 2'h1 ? 1'b0 : c[9+2*i] & (mm[i] ^ !c[8+2*i]);
        end
        o = o | (4'hA & {c[14] & !c[15], c[12] & !c[13], c[10] & !c[11], c[8] & !c[9]});
        return {20'h0, o, oe, (oe & o) | (~oe & ext)};
    endfunction
    task automatic close_out();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial forever #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, m, ext} <= {4'h0, 12'h000, 32'h0, 8'h06};
        strb <= 4'hF;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        chk("reset status", rd, 32'h6);
        apb(1'b0, 12'h004, 32'h0);
        chk("reset gp out", rd, 32'h0);
        apb(1'b1, 12'h004, 32'hA);
        apb(1'b0, 12'h004, 32'h0);
        chk("gp out", rd, 32'hA);
        strb <= 4'hE;
        apb(1'b1, 12'h004, 32'h5);
        strb <= 4'hF;
        apb(1'b0, 12'h004, 32'h0);
        chk("gp out lane off", rd, 32'hA);
        apb(1'b0, 12'h000, 32'h0);
        chk("config read", {rd[30:0], er}, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {31'h0, er}, 32'h1);
        for (int r = 0; r < 4; r++) begin
            cv = 32'h0;
            for (int i = 0; i < 4; i++) cv[8+2*i+:2] = 2'(i + r);
            apb(1'b1, 12'h000, cv);
            for (int p = 0; p < 2; p++) begin
                m <= p ? 4'hA : 4'h5;
                repeat (3) @(posedge pclk);
                apb(1'b0, 12'h008, 32'h0);
                chk("status", rd, stat(cv, m));
                chk("terminals", {20'h0, pin_out, pin_oe, lvl}, stat(cv, m));
            end
        end
        close_out();
    end
endmodule
`default_nettype wire
